// File: rtl/kwi_pkg.sv
package kwi_pkg;

  // -------------------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // -------------------------------------------------------------------------
  localparam logic [7:0] KEYPAD_STATUS_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] KEYPAD_PIN_ENABLE_ADDR     = 8'h04;
  localparam logic [7:0] KEY_SYSTEM_CONTROL_ADDR    = 8'h08;

  // -------------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------------
  localparam int KEY_PENDING_FLAG_POS = 3;
  localparam int KEY_ACKNOWLEDGE_POS  = 2;
  localparam int KEY_IRQ_MASK_POS     = 1;
  localparam int KEY_LEVEL_SENSE_POS  = 0;
  localparam int BREAK_STATE_POS      = 1;
  localparam int BREAK_CLEAR_POS      = 0;

  // -------------------------------------------------------------------------
  // Sizes and reset values
  // -------------------------------------------------------------------------
  localparam int         KEY_PINS          = 5;
  localparam int         ADDR_W            = 8;
  localparam logic [4:0] PIN_ENABLE_RESET  = 5'h00;
  localparam int         SYNC_STAGES       = 2;

  typedef enum logic [1:0] {
    KWI_IDLE,
    KWI_PENDING,
    KWI_HELD
  } kwi_req_state_t;

endpackage : kwi_pkg

// File: rtl/kwi_pin_sync.sv
module kwi_pin_sync (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [4:0] pinIn,
  output logic      [4:0] pinSync
);

  logic [4:0] stage1_r;

  // --------------------------------------------------------------------------
  // Two-stage synchroniser per pin
  // --------------------------------------------------------------------------
  // Reset to high so a key held low at reset shows as a fresh falling edge once reset ends
  genvar g;
  generate
    for (g = 0; g < kwi_pkg::KEY_PINS; g++) begin : gSync
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          stage1_r[g] <= 1'b1;
          pinSync[g]  <= 1'b1;
        end else begin
          stage1_r[g] <= pinIn[g];
          pinSync[g]  <= stage1_r[g];
        end
      end
    end
  endgenerate

endmodule : kwi_pin_sync

// File: rtl/kwi_keypad_wake.sv
// Notes on behaviour
// - Each pin enable bit alone decides if its pin joins detection.
// - An enabled pin also has its internal pullup switched on.
// - Latch a request when an enabled pin falls after all were high.
// - Edge-only: no request while another enabled pin is already low.
// - Edge-and-level: request stays while any enabled pin is low.
// - Edge-and-level: clears only after acknowledge and all pins high, any order.
// - A vector fetch acknowledges exactly like a software acknowledge; here a fetch still acknowledges in break with clear-enable zero.
// - Writing one to acknowledge bit acknowledges; it reads as zero.
// - Acknowledge never blocks later edges; a later fall latches anew.
// - Edge-only: any acknowledge clears the request at once.
// - Reset clears the request and the sense mode, even with pins low.
// - Pending flag shows the request regardless of mask; reset clears it.
// - Mask bit set keeps the request from the CPU; reset clears mask.
// - Sense bit one: edges plus low levels; zero: edges only.
// - An enabled pin is forced to input over its direction bit.
// - Upper four status bits read as zero.
// - Detection runs in wait and stop; unmasked request wakes the CPU.
// - In break with clear-enable zero, acknowledge writes do nothing.
// - Reset clears all pin enable bits.
//
// Local design decisions: the APB register port and the register offsets.
module kwi_keypad_wake (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  keyPin,
  input  wire logic [4:0]  pinDirection,
  input  wire logic        vectorFetch,
  input  wire logic        breakState,
  output logic             keyIrq,
  output logic             keyWake,
  output logic      [4:0]  pullupEnable,
  output logic      [4:0]  pinOutputAllow
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [4:0]     keyPinEnable_r;
  logic           keyIrqMask_r;
  logic           keyLevelSense_r;
  logic           breakClearFlagEnable_r;
  logic           request_r;
  logic           ackSeen_r;
  logic           anyLowPrev_r;
  logic           breakSync1_r;
  logic           breakSync_r;
  logic           fetchSync1_r;
  logic           fetchSync_r;
  logic           fetchPrev_r;
  logic [4:0]     pinSync;
  logic           anyLow;
  logic           fallEvent;
  logic           apbAccess;
  logic           apbWrite;
  logic           addrHit;
  logic           swAck;
  logic           fetchAck;
  logic           ackAny;
  logic [4:0]     enabledLow;
  logic           readStart;
  logic           selStatus;
  logic           selEnable;
  logic           selSystem;
  logic           wrStatus;
  logic           wrEnable;
  logic           wrSystem;
  logic [31:0]    prdata_nxt;
  kwi_pkg::kwi_req_state_t reqState;

  // --------------------------------------------------------------------------
  // Pin synchronisation
  // --------------------------------------------------------------------------
  kwi_pin_sync uSync (
    .clock   (clock),
    .reset   (reset),
    .pinIn   (keyPin),
    .pinSync (pinSync)
  );

  // --------------------------------------------------------------------------
  // CPU-side strobes
  // --------------------------------------------------------------------------
  // Break state and vector fetch come from the CPU side; treated as async
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      breakSync1_r <= 1'b0;
      breakSync_r  <= 1'b0;
    end else begin
      breakSync1_r <= breakState;
      breakSync_r  <= breakSync1_r;
    end
  end

  // A long fetch strobe gives one acknowledge: only its rising edge counts
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fetchSync1_r <= 1'b0;
      fetchSync_r  <= 1'b0;
      fetchPrev_r  <= 1'b0;
    end else begin
      fetchSync1_r <= vectorFetch;
      fetchSync_r  <= fetchSync1_r;
      fetchPrev_r  <= fetchSync_r;
    end
  end

  // --------------------------------------------------------------------------
  // Detection
  // --------------------------------------------------------------------------
  // Disabled pins count as high so they neither trigger nor block
  // Per-pin term: a pin counts only while it is both low and enabled
  genvar p;
  generate
    for (p = 0; p < kwi_pkg::KEY_PINS; p++) begin : gDetect
      assign enabledLow[p] = ~pinSync[p] & keyPinEnable_r[p];
    end
  endgenerate

  assign anyLow    = |enabledLow;
  // Only the first pin to fall out of all-high fires
  assign fallEvent = anyLow & ~anyLowPrev_r;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      anyLowPrev_r <= 1'b0;
    end else begin
      anyLowPrev_r <= anyLow;
    end
  end

  // --------------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------------
  assign apbAccess = psel & penable;
  // Writes land only at the edge that completes the transfer, so a write-one
  // acknowledge acts exactly once per transfer
  assign apbWrite  = apbAccess & pready & pwrite & pstrb[0];
  // Read data is looked up in the first access cycle and held by the answer flops
  assign readStart = apbAccess & ~pready & ~pwrite;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  assign selStatus = (paddr == kwi_pkg::KEYPAD_STATUS_CONTROL_ADDR);
  assign selEnable = (paddr == kwi_pkg::KEYPAD_PIN_ENABLE_ADDR);
  assign selSystem = (paddr == kwi_pkg::KEY_SYSTEM_CONTROL_ADDR);
  assign addrHit   = selStatus | selEnable | selSystem;
  assign wrStatus  = apbWrite & selStatus;
  assign wrEnable  = apbWrite & selEnable;
  assign wrSystem  = apbWrite & selSystem;

  // --------------------------------------------------------------------------
  // Acknowledge sources
  // --------------------------------------------------------------------------
  // Software acknowledge blocked in break unless clearing is allowed; a fetch acknowledge is not
  assign swAck    = wrStatus & pwdata[kwi_pkg::KEY_ACKNOWLEDGE_POS] &
                    (~breakSync_r | breakClearFlagEnable_r);
  assign fetchAck = fetchSync_r & ~fetchPrev_r;
  assign ackAny   = swAck | fetchAck;

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      keyIrqMask_r <= 1'b0;
    end else if (wrStatus) begin
      keyIrqMask_r <= pwdata[kwi_pkg::KEY_IRQ_MASK_POS];
    end
  end

  // A sense change takes effect the cycle after the write that carries it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      keyLevelSense_r <= 1'b0;
    end else if (wrStatus) begin
      keyLevelSense_r <= pwdata[kwi_pkg::KEY_LEVEL_SENSE_POS];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      keyPinEnable_r <= kwi_pkg::PIN_ENABLE_RESET;
    end else if (wrEnable) begin
      keyPinEnable_r <= pwdata[4:0];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      breakClearFlagEnable_r <= 1'b0;
    end else if (wrSystem) begin
      breakClearFlagEnable_r <= pwdata[kwi_pkg::BREAK_CLEAR_POS];
    end
  end

  // --------------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------------
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    case (paddr)
      kwi_pkg::KEYPAD_STATUS_CONTROL_ADDR: begin
        // Upper nibble and acknowledge bit read as zero
        prdata_nxt[kwi_pkg::KEY_PENDING_FLAG_POS] = request_r;
        prdata_nxt[kwi_pkg::KEY_IRQ_MASK_POS]     = keyIrqMask_r;
        prdata_nxt[kwi_pkg::KEY_LEVEL_SENSE_POS]  = keyLevelSense_r;
      end
      kwi_pkg::KEYPAD_PIN_ENABLE_ADDR: begin
        prdata_nxt[4:0] = keyPinEnable_r;
      end
      kwi_pkg::KEY_SYSTEM_CONTROL_ADDR: begin
        prdata_nxt[kwi_pkg::BREAK_STATE_POS] = breakSync_r;
        prdata_nxt[kwi_pkg::BREAK_CLEAR_POS] = breakClearFlagEnable_r;
      end
      default: begin
        prdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Bus answer
  // --------------------------------------------------------------------------
  // Registered answer: one wait state, ready in the second access cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= apbAccess & ~pready;
    end
  end

  // Unmapped addresses answer with an error and change nothing
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= apbAccess & ~pready & ~addrHit;
    end
  end

  // Read data stands with ready only; an idle bus shows zero
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= readStart ? prdata_nxt : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Request latch
  // --------------------------------------------------------------------------
  // ackSeen remembers an acknowledge that arrived while pins were still low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      request_r <= 1'b0;
      ackSeen_r <= 1'b0;
    end else begin
      if (fallEvent) begin
        // A fresh edge wins over a same-cycle acknowledge
        request_r <= 1'b1;
        ackSeen_r <= 1'b0;
      end else if (!keyLevelSense_r) begin
        if (ackAny) begin
          request_r <= 1'b0;
        end
        ackSeen_r <= 1'b0;
      end else if (request_r) begin
        // Both acknowledge and all-high needed, in either order
        if ((ackAny || ackSeen_r) && !anyLow) begin
          request_r <= 1'b0;
          ackSeen_r <= 1'b0;
        end else if (ackAny) begin
          ackSeen_r <= 1'b1;
        end
      end else if (anyLow) begin
        // Level mode keeps a request present while any pin is low
        request_r <= ~ackSeen_r;
      end else begin
        ackSeen_r <= 1'b0;
      end
    end
  end

  always_comb begin
    if (!request_r) begin
      reqState = kwi_pkg::KWI_IDLE;
    end else if (ackSeen_r) begin
      reqState = kwi_pkg::KWI_HELD;
    end else begin
      reqState = kwi_pkg::KWI_PENDING;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // No clock gating here, so detection keeps running in wait and stop
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      keyIrq  <= 1'b0;
      keyWake <= 1'b0;
    end else begin
      keyIrq  <= request_r & ~keyIrqMask_r;
      keyWake <= (reqState != kwi_pkg::KWI_IDLE) & ~keyIrqMask_r;
    end
  end

  // --------------------------------------------------------------------------
  // Pad control
  // --------------------------------------------------------------------------
  // Pullups follow the enables a cycle late; a pin is not settled high at once,
  // so software masks and acknowledges after enabling
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pullupEnable <= 5'h00;
    end else begin
      pullupEnable <= keyPinEnable_r;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pinOutputAllow <= 5'h00;
    end else begin
      pinOutputAllow <= pinDirection & ~keyPinEnable_r;
    end
  end

endmodule : kwi_keypad_wake

// File: sim/kwi_keypad_wake_assertions.sv
module kwi_keypad_checker (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        keyIrq,
  input wire logic        keyWake,
  input wire logic [4:0]  pullupEnable,
  input wire logic [4:0]  pinOutputAllow
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // -------------------------------------------------------------------------
  // Bus answer
  // -------------------------------------------------------------------------
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle into access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_status_zero: assert property (pready && !pwrite &&
    paddr == kwi_pkg::KEYPAD_STATUS_CONTROL_ADDR |-> prdata[7:4] == 4'h0 && !prdata[2])
    else $error("status unused or acknowledge bit read nonzero");
  // -------------------------------------------------------------------------
  // Pins and request
  // -------------------------------------------------------------------------
  a_wake_irq: assert property (keyWake == keyIrq)
    else $error("wake differs from interrupt");
  a_input_forced: assert property ((pinOutputAllow & pullupEnable) == 5'h00)
    else $error("enabled pin left as output");
  // A pin enable change may only follow a stored write to the enable register
  a_enable_write: assert property (!$stable(pullupEnable) |->
    $past(psel && penable && pready && pwrite && paddr == kwi_pkg::KEYPAD_PIN_ENABLE_ADDR, 2))
    else $error("pin enable changed without write");
  a_reset_clear: assert property ($fell(reset) |->
    pullupEnable == 5'h00 && !keyIrq && prdata == 32'h0)
    else $error("state not cleared by reset");
endmodule : kwi_keypad_checker

bind kwi_keypad_wake kwi_keypad_checker kwi_keypad_checker_inst (.clock(clock),
  .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .keyIrq(keyIrq),
  .keyWake(keyWake), .pullupEnable(pullupEnable), .pinOutputAllow(pinOutputAllow));

// File: sim/kwi_key_model.sv
module kwi_key_model (
  input  wire logic       clock,
  input  wire logic [4:0] press,
  input  wire logic [4:0] pullupEnable,
  output logic      [4:0] keyPin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] floatPat;
  initial floatPat = 5'h15;
  // Unpulled pins float: toggle so a lucky settle to one level cannot hide faults
  always @(posedge clock) floatPat <= ~floatPat;
  assign keyPin = ~press & (pullupEnable | floatPat);
endmodule : kwi_key_model

// File: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] SC = kwi_pkg::KEYPAD_STATUS_CONTROL_ADDR;
  localparam logic [7:0] EN = kwi_pkg::KEYPAD_PIN_ENABLE_ADDR;
  localparam logic [7:0] SY = kwi_pkg::KEY_SYSTEM_CONTROL_ADDR;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, vectorFetch, breakState;
  logic keyIrq, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, seed, r;
  logic [3:0] pstrb;
  logic [4:0] keyPin, pinDirection, pullupEnable, pinOutputAllow, press;
  int n_mismatch, total_checks, k;
  kwi_keypad_wake kwi_keypad_wake_inst (.clock, .reset, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .keyPin, .pinDirection,
    .vectorFetch, .breakState, .keyIrq, .keyWake(), .pullupEnable, .pinOutputAllow);
  kwi_key_model kwi_key_model_inst (.clock, .press, .pullupEnable, .keyPin);
  always #10 clock = ~clock;
  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] st(logic p, logic m, logic s);
    return {28'h0, p, 1'b0, m, s};
  endfunction : st
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Answer is taken at the rising edge where ready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock) penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task automatic settle();
    repeat (8) @(negedge clock);
  endtask : settle
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
  // -------------------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------------------
  initial begin
    {clock, reset, psel, penable, pwrite, vectorFetch, breakState} = 7'h20;
    {paddr, pwdata, pstrb, pinDirection, press, seed} = {40'h0, 4'hF, 5'h1F, 5'h0, 32'h0000E88E};
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rd(SC, st(0, 0, 0));
    rd(EN, 32'h0);
    rd(8'h0C, 32'h0);
    chk(err, 1'b1);
    apb(1, SC, 32'h2); apb(1, EN, 32'h1F); apb(1, SC, 32'h6); apb(1, SC, 32'h0);
    settle();
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      k = r % 5;
      @(posedge clock) {press, pinDirection} <= {5'h1 << k, r[9:5]};
      settle();
      chk(keyIrq, 1'b1);
      rd(SC, st(1, 0, 0));
      if (r[0]) apb(1, SC, 32'h4);
      else begin
        @(posedge clock) vectorFetch <= 1'b1;
        repeat (3) @(posedge clock);
        vectorFetch <= 1'b0;
      end
      settle();
      chk(keyIrq, 1'b0);
      @(posedge clock) press <= press | (5'h1 << ((k + 1) % 5));
      settle();
      chk(keyIrq, 1'b0);
      chk(pinOutputAllow, 5'h0);
      @(posedge clock) press <= 5'h0;
      settle();
    end
    apb(1, SC, 32'h2);
    @(posedge clock) press <= 5'h4;
    settle();
    chk(keyIrq, 1'b0);
    rd(SC, st(1, 1, 0));
    apb(1, SC, 32'h5);
    settle();
    rd(SC, st(1, 0, 1));
    chk(keyIrq, 1'b1);
    @(posedge clock) press <= 5'h0;
    settle();
    chk(keyIrq, 1'b1);
    apb(1, SC, 32'h5);
    settle();
    chk(keyIrq, 1'b0);
    rd(SC, st(0, 0, 1));
    apb(1, SC, 32'h0);
    @(posedge clock) {breakState, press} <= {1'b1, 5'h10};
    settle();
    apb(1, SC, 32'h4);
    settle();
    chk(keyIrq, 1'b1);
    apb(1, SY, 32'h1); apb(1, SC, 32'h4);
    settle();
    chk(keyIrq, 1'b0);
    @(posedge clock) {breakState, press} <= 6'h0;
    apb(1, EN, 32'h1E);
    @(posedge clock) press <= 5'h1;
    settle();
    chk(keyIrq, 1'b0);
    chk(pullupEnable, 5'h1E);
    chk(pinOutputAllow, pinDirection & 5'h01);
    end_of_test();
  end
endmodule : tb_top
